// [core/qri_consts.svh]
// timing constants of the parallel rgb pixel input
`ifndef QRI_CONSTS_SVH
`define QRI_CONSTS_SVH
`define QRI_ACTIVE_PIXELS   9'h140
`define QRI_ACTIVE_LINES    9'h0f0
`define QRI_TOP_BLANK_LINES 9'h007
`define QRI_FIRST_LINE      9'h008
`define QRI_DEFAULT_START   9'h034
`define QRI_LEVEL_BITS      6
`define QRI_SYNC_STAGES     2
`endif

// [core/qri_pkg.sv]
// shared types of the parallel rgb pixel input
`include "qri_consts.svh"
package qri_pkg;
    typedef logic [`QRI_LEVEL_BITS-1:0] qri_level_t;
    typedef logic [8:0]                 qri_count_t;
endpackage

// [core/qri_rx.sv]
// receiver of the 18-bit parallel rgb pixel port with sync and strobe
`timescale 1ns/1ps
`include "qri_consts.svh"

// Operation
// - exactly 320 active pixels per line
// - top blanking is exactly 7 lines
// - exactly 240 active lines per frame
// - strobe rising edge sets first pixel
// - strobe held low starts at clock 52
// - vertical window starts at line 8
// - strobe positions lines only if it rose in the previous frame
// - six-bit binary level per colour
// - pixel is 18 parallel active-high bits
module qri_rx
    import qri_pkg::*;
(
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // pixel port pins, all asynchronous to sys_clk
    input  wire logic       pix_clk,
    input  wire logic       line_sync_n,
    input  wire logic       frame_sync_n,
    input  wire logic       active_pixel_strobe,
    input  wire qri_level_t red_level_bits,
    input  wire qri_level_t green_level_bits,
    input  wire qri_level_t blue_level_bits,
    // captured pixel stream
    output logic            pix_valid_q,
    output qri_level_t      pix_red_q,
    output qri_level_t      pix_green_q,
    output qri_level_t      pix_blue_q,
    output qri_count_t      pix_col_q,
    output qri_count_t      pix_row_q,
    output logic            frame_start_q
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int W = 22;
    // idle pin levels: clock low, syncs high, strobe low, black data
    // so that release of reset shows no false sync or strobe edge
    localparam logic [W-1:0] SY_IDLE = {1'b0, 1'b1, 1'b1, 1'b0, 18'h00000};
    logic [W-1:0] sy1_q, sy1_d;   // first stage, read only by second
    logic [W-1:0] sy2_q, sy2_d;   // second stage, safe to use
    logic         ck_prev_q, ck_prev_d; // pixel clock one sample back

    // two flops on every pin before logic sees it
    always_comb begin
        sy1_d     = {pix_clk, line_sync_n, frame_sync_n, active_pixel_strobe,
                     red_level_bits, green_level_bits, blue_level_bits};
        sy2_d     = sy1_q;
        ck_prev_d = sy2_q[21];
    end

    // synchroniser registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q     <= SY_IDLE;
            sy2_q     <= SY_IDLE;
            ck_prev_q <= 1'b0;
        end else begin
            sy1_q     <= sy1_d;
            sy2_q     <= sy2_d;
            ck_prev_q <= ck_prev_d;
        end
    end

    // ************************************************************
    // pixel clock edge and sync decode
    // ************************************************************
    logic       tick;     // rising pixel clock edge seen
    logic       hs, vs, de;
    logic [17:0] rgb;     // red, green, blue from high to low
    assign tick = sy2_q[21] & ~ck_prev_q;
    assign hs   = ~sy2_q[20];
    assign vs   = ~sy2_q[19];
    assign de   = sy2_q[18];
    assign rgb  = sy2_q[17:0];

    // ************************************************************
    // timing state
    // ************************************************************
    logic       hs_prev_q, hs_prev_d;   // line sync at last tick
    logic       vs_prev_q, vs_prev_d;   // frame sync at last tick
    logic       de_prev_q, de_prev_d;   // strobe at last tick
    qri_count_t h_cnt_q, h_cnt_d;       // clocks since line sync
    qri_count_t line_q, line_d;         // lines since frame sync
    qri_count_t col_q, col_d;           // next active column
    logic       run_q, run_d;           // horizontal window open
    logic       done_q, done_d;         // this line already shown
    logic       seen_q, seen_d;         // strobe rose in this frame
    logic       de_mode_q, de_mode_d;   // strobe positions lines
    logic       hs_edge, vs_edge, de_rise, v_act, start;
    qri_count_t h_nx;                   // h_cnt after this tick
    logic       out_v_d, fs_d;
    qri_level_t r_d, g_d, b_d;
    qri_count_t oc_d, or_d;

    // next-state logic of counters, window and capture
    always_comb begin
        hs_edge   = tick & hs & ~hs_prev_q;
        vs_edge   = tick & vs & ~vs_prev_q;
        de_rise   = tick & de & ~de_prev_q;
        hs_prev_d = tick ? hs : hs_prev_q;
        vs_prev_d = tick ? vs : vs_prev_q;
        de_prev_d = tick ? de : de_prev_q;
        h_cnt_d   = h_cnt_q;
        line_d    = line_q;
        col_d     = col_q;
        run_d     = run_q;
        done_d    = done_q;
        seen_d    = seen_q | de_rise;
        de_mode_d = de_mode_q;
        out_v_d   = 1'b0;
        fs_d      = 1'b0;
        r_d       = pix_red_q;
        g_d       = pix_green_q;
        b_d       = pix_blue_q;
        oc_d      = pix_col_q;
        or_d      = pix_row_q;
        // count clocks within the line, saturating
        h_nx = hs_edge ? 9'h000 : ((h_cnt_q == 9'h1ff) ? h_cnt_q : h_cnt_q + 9'h001);
        // vertical window from line 8 for 240 lines, strobe plays no part
        // fixed line 8
        v_act = (line_q >= `QRI_FIRST_LINE) &&
                (line_q < `QRI_FIRST_LINE + `QRI_ACTIVE_LINES);
        start = tick & v_act & ~run_q & ~done_q & ~hs_edge &
                (de_mode_q ? de_rise : (h_nx == `QRI_DEFAULT_START));
        if (tick) begin
            h_cnt_d = h_nx;
        end
        // a new line rearms the window
        if (hs_edge) begin
            line_d = (line_q == 9'h1ff) ? line_q : line_q + 9'h001;
            run_d  = 1'b0;
            done_d = 1'b0;
            col_d  = '0;
        end
        // frame sync restarts line count and picks the position mode
        if (vs_edge) begin
            line_d    = '0;
            fs_d      = 1'b1;
            de_mode_d = seen_q | de_rise;
            seen_d    = 1'b0;
        end
        if (tick && (run_q || start) && !hs_edge) begin
            out_v_d = 1'b1;
            r_d  = rgb[17:12];
            g_d  = rgb[11:6];
            b_d  = rgb[5:0];
            oc_d = col_q;
            or_d = line_q - `QRI_FIRST_LINE;
            if (col_q == `QRI_ACTIVE_PIXELS - 9'h001) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                run_d  = 1'b1;
            end
            col_d = col_q + 9'h001;
        end
    end

    // timing and output registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_prev_q     <= 1'b0;
            vs_prev_q     <= 1'b0;
            de_prev_q     <= 1'b0;
            h_cnt_q       <= 9'h1ff;
            line_q        <= 9'h1ff;
            col_q         <= '0;
            run_q         <= 1'b0;
            done_q        <= 1'b0;
            seen_q        <= 1'b0;
            de_mode_q     <= 1'b0;
            pix_valid_q   <= 1'b0;
            pix_red_q     <= '0;
            pix_green_q   <= '0;
            pix_blue_q    <= '0;
            pix_col_q     <= '0;
            pix_row_q     <= '0;
            frame_start_q <= 1'b0;
        end else begin
            hs_prev_q     <= hs_prev_d;
            vs_prev_q     <= vs_prev_d;
            de_prev_q     <= de_prev_d;
            h_cnt_q       <= h_cnt_d;
            line_q        <= line_d;
            col_q         <= col_d;
            run_q         <= run_d;
            done_q        <= done_d;
            seen_q        <= seen_d;
            de_mode_q     <= de_mode_d;
            pix_valid_q   <= out_v_d;
            pix_red_q     <= r_d;
            pix_green_q   <= g_d;
            pix_blue_q    <= b_d;
            pix_col_q     <= oc_d;
            pix_row_q     <= or_d;
            frame_start_q <= fs_d;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // window opening in each position mode
    sequence strobe_open_s;
        start && de_mode_q;
    endsequence
    sequence default_open_s;
        start && !de_mode_q;
    endsequence

    col_range_a: assert property (pix_valid_q |-> pix_col_q < `QRI_ACTIVE_PIXELS)
        else $error("column beyond 320");
    row_range_a: assert property (pix_valid_q |-> pix_row_q < `QRI_ACTIVE_LINES)
        else $error("row beyond 240");
    top_blank_a: assert property (out_v_d |-> line_q > `QRI_TOP_BLANK_LINES)
        else $error("pixel inside 7 top blank lines");
    first_row_a: assert property (
        pix_valid_q && pix_row_q == 9'h000 |-> $past(line_q) == `QRI_FIRST_LINE)
        else $error("first row not at line 8");
    strobe_start_a: assert property (
        strobe_open_s |-> de_rise ##1 pix_valid_q && pix_col_q == 9'h000)
        else $error("strobe edge did not open column 0");
    default_start_a: assert property (
        default_open_s |-> h_nx == `QRI_DEFAULT_START ##1 pix_col_q == 9'h000)
        else $error("default start not at clock 52");
    vert_window_a: assert property (!v_act && !run_q |=> !pix_valid_q)
        else $error("pixel outside vertical window");
    tick_capture_a: assert property (pix_valid_q |-> $past(tick))
        else $error("pixel without pixel clock edge");
    data_map_a: assert property (
        pix_valid_q |-> {pix_red_q, pix_green_q, pix_blue_q} == $past(rgb))
        else $error("pixel bits altered");
    level_map_a: assert property (out_v_d |=> pix_blue_q == $past(rgb[5:0]))
        else $error("blue level altered");

endmodule

// [testbench/qri_ctrl_model.sv]
// timing controller model that drives the pixel port pins
`timescale 1ns/1ps
module qri_ctrl_model
    import qri_pkg::*;
(
    // pixel port pins
    output logic       pix_clk,
    output logic       line_sync_n,
    output logic       frame_sync_n,
    output logic       active_pixel_strobe,
    output qri_level_t red_level_bits,
    output qri_level_t green_level_bits,
    output qri_level_t blue_level_bits
);
    localparam int  LINE_CLOCKS = 400;
    localparam real HALF_NS     = 400.0;

    initial begin
        pix_clk             = 1'b0;
        line_sync_n         = 1'b1;
        frame_sync_n        = 1'b1;
        active_pixel_strobe = 1'b0;
        red_level_bits      = 6'h00;
        green_level_bits    = 6'h00;
        blue_level_bits     = 6'h00;
    end

    // one frame; strobe_at of 0 keeps the strobe low, clock stands still after it
    // frame length is the caller's; short frames keep the run brief
    task automatic run_frame(input int lines, input int strobe_at);
        // callers stand on a system clock edge: move every pin edge just after it
        #1;
        for (int ln = 0; ln < lines; ln++) begin
            for (int h = 0; h < LINE_CLOCKS; h++) begin
                line_sync_n         = !(h < 5);
                frame_sync_n        = !(ln < 2);
                active_pixel_strobe = (strobe_at != 0) && (h >= strobe_at)
                                      && (h < strobe_at + 320);
                red_level_bits      = qri_level_t'(h);
                green_level_bits    = qri_level_t'(ln);
                blue_level_bits     = ~qri_level_t'(h);
                #HALF_NS pix_clk = 1'b1;
                #HALF_NS pix_clk = 1'b0;
            end
        end
        line_sync_n         = 1'b1;
        frame_sync_n        = 1'b1;
        active_pixel_strobe = 1'b0;
    endtask
endmodule

// [testbench/qri_rx_tb.sv]
// self-checking bench of the parallel rgb pixel receiver
`timescale 1ns/1ps
`include "qri_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module qri_rx_tb
    import qri_pkg::*;
;
    // clock, reset and bookkeeping
    logic       sys_clk   = 1'b0;
    logic       rst_n;
    int         bad_count = 0;
    int         cmp_count = 0;
    int         cyc       = 0;
    int         npix      = 0;
    int         nstart    = 0;
    int         start_h   = 0;
    // pixel port pins
    logic       pix_clk;
    logic       line_sync_n;
    logic       frame_sync_n;
    logic       active_pixel_strobe;
    qri_level_t red_level_bits;
    qri_level_t green_level_bits;
    qri_level_t blue_level_bits;
    // captured stream
    logic       pix_valid_q;
    qri_level_t pix_red_q;
    qri_level_t pix_green_q;
    qri_level_t pix_blue_q;
    qri_count_t pix_col_q;
    qri_count_t pix_row_q;
    logic       frame_start_q;

    always #50 sys_clk = ~sys_clk;

    qri_ctrl_model ctrl (
        .pix_clk(pix_clk), .line_sync_n(line_sync_n), .frame_sync_n(frame_sync_n),
        .active_pixel_strobe(active_pixel_strobe), .red_level_bits(red_level_bits),
        .green_level_bits(green_level_bits), .blue_level_bits(blue_level_bits)
    );

    qri_rx dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .pix_clk(pix_clk), .line_sync_n(line_sync_n),
        .frame_sync_n(frame_sync_n), .active_pixel_strobe(active_pixel_strobe),
        .red_level_bits(red_level_bits), .green_level_bits(green_level_bits),
        .blue_level_bits(blue_level_bits), .pix_valid_q(pix_valid_q),
        .pix_red_q(pix_red_q), .pix_green_q(pix_green_q), .pix_blue_q(pix_blue_q),
        .pix_col_q(pix_col_q), .pix_row_q(pix_row_q), .frame_start_q(frame_start_q)
    );

    // checks every captured pixel against the pattern the controller sent
    // sampled on the falling edge, where registered outputs are settled
    always @(negedge sys_clk) begin
        if (pix_valid_q === 1'b1) begin
            npix++;
            `CHK("col range", 1'b1, pix_col_q < `QRI_ACTIVE_PIXELS)
            `CHK("red", qri_level_t'(pix_col_q + start_h), pix_red_q)
            `CHK("blue", ~qri_level_t'(pix_col_q + start_h), pix_blue_q)
            `CHK("green", qri_level_t'(pix_row_q + `QRI_FIRST_LINE), pix_green_q)
        end
        if (frame_start_q === 1'b1) begin
            nstart++;
        end
    end

    // hang guard, the run needs about 74000 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            test_done();
        end
    end

    // strobe low in the first frame after reset: start at clock 52, one active line
    task automatic default_start();
        npix    = 0;
        nstart  = 0;
        start_h = 52;
        ctrl.run_frame(9, 0);
        repeat (20) @(posedge sys_clk);
        `CHK("pixels", 320, npix)
        `CHK("frame starts", 1, nstart)
    endtask

    // strobe seen in a short frame, next frame starts at the strobe, two lines;
    // frame sync drops after two of four lines so the next frame shows a sync edge
    task automatic strobe_start();
        ctrl.run_frame(4, 30);
        repeat (20) @(posedge sys_clk);
        npix    = 0;
        nstart  = 0;
        start_h = 30;
        ctrl.run_frame(10, 30);
        repeat (20) @(posedge sys_clk);
        `CHK("pixels", 640, npix)
        `CHK("frame starts", 1, nstart)
    endtask

    // prints the counts and the verdict, then ends the run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // reset for 12 cycles, then the scenarios
    initial begin
        rst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        default_start();
        strobe_start();
        test_done();
    end
endmodule
